// *** include/fgqe_pkg.sv ***
// Shared constants and types for the feedback, gearing and quadrature emulation block.
// Assumes a 100 MHz single clock domain and a synchronous active-high reset.
package fgqe_pkg;
   localparam int          CLK_MHZ          = 100;
   localparam int          POS_W            = 19;
   localparam int          TURN_W           = 16;
   localparam int          SER_W            = 32;
   // Feedback type codes for the 24 V quadrature input and the resolver
   localparam logic [5:0]  FBT_QUAD24_STORE = 6'h0c;
   localparam logic [5:0]  FBT_QUAD24_SHAKE = 6'h10;
   localparam logic [5:0]  FBT_RESOLVER     = 6'h00;
   // Emulation function and gearing source codes
   localparam logic [4:0]  EMU_FN_QUAD      = 5'h09;
   localparam logic [4:0]  EMU_FN_SERIAL    = 5'h0a;
   localparam logic [4:0]  GEAR_STEPDIR24   = 5'h01;
   localparam logic [4:0]  GEAR_QUAD24      = 5'h02;
   localparam logic [4:0]  GEAR_SERIAL      = 5'h19;
   // Line count limits and reset count before multiplication, and the supply monitor bit
   localparam logic [19:0] LINES_RES_MIN    = 20'h00020;
   localparam logic [19:0] LINES_RES_MAX    = 20'h01000;
   localparam logic [19:0] LINES_ENC_MIN    = 20'h00100;
   localparam logic [19:0] LINES_ENC_MAX    = 20'h80000;
   localparam logic [19:0] LINES_SAFE_MAX   = 20'h01000;
   localparam logic [19:0] LINES_RESET      = 20'h00400;
   localparam int          SUPPLY_MON_BIT   = 20;
   // Least count period of the 24 V inputs: 100 kHz gives 10000 ns
   localparam int          QUAD24_PERIOD_NS = 10000;
   localparam int          QUAD24_PERIOD_CY = (QUAD24_PERIOD_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [3:0] {
      FGQE_ST_IDLE  = 4'b0001,
      FGQE_ST_LOAD  = 4'b0010,
      FGQE_ST_SHAKE = 4'b0100,
      FGQE_ST_RUN   = 4'b1000
   } fgqe_comm_t;
endpackage

// *** verilog/fgqe_quad_decoder.sv ***
// Quadrature and step/direction decoder for the fast digital inputs.
// Assumes raw pins from outside the clock domain; they are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module fgqe_quad_decoder (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        stepMode,
   input  wire logic        pinA,
   input  wire logic        pinB,
   output logic             countUp,
   output logic             countDown
);
   import fgqe_pkg::*;
   logic [2:0] syncA_q;
   logic [2:0] syncB_q;
   logic       stA_q;
   logic       stB_q;
   wire        agreeA = syncA_q[1] == syncA_q[2];
   wire        agreeB = syncB_q[1] == syncB_q[2];
   wire        newA   = agreeA ? syncA_q[2] : stA_q;
   wire        newB   = agreeB ? syncB_q[2] : stB_q;
   wire        chA    = newA != stA_q;
   wire        chB    = newB != stB_q;
   // Gray step direction: forward when new A differs from old B
   wire        qUp    = (chA ^ chB) && (newA ^ stB_q);
   wire        qDn    = (chA ^ chB) && !(newA ^ stB_q);
   wire        stepEd = newA && !stA_q;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         syncA_q <= 3'h0;
         syncB_q <= 3'h0;
         stA_q   <= 1'b0;
         stB_q   <= 1'b0;
      end else begin
         syncA_q <= {syncA_q[1:0], pinA};
         syncB_q <= {syncB_q[1:0], pinB};
         stA_q   <= newA;
         stB_q   <= newB;
      end
   end
   // Step mode: A is step, B is direction
   assign countUp   = stepMode ? (stepEd && newB) : qUp;
   assign countDown = stepMode ? (stepEd && !newB) : qDn;
endmodule
`default_nettype wire

// *** verilog/fgqe_top.sv ***
// Position feedback, electronic gearing and A/B quadrature emulation of a servo drive.
// Assumes absolute shaft position arrives each cycle on the same clock; pins are async.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Emulation drives A and B in quadrature, 90 degrees apart, plus zero pulse.
// - Zero pulse once per revolution, only while A and B are both high.
// - Line count 32..4096 with resolver, 2^8..2^19 with encoder.
// - With safety option only power-of-two counts up to 2^12 accepted.
// - Zero pulse offset moves pulse anywhere in a turn, taken from the input every cycle.
// - Default count rises for clockwise shaft rotation.
// - Emulated pulses come from the cyclic absolute shaft position.
// - After supply power-up, commutation start info obtained before position control.
// - Type 12 loads stored phase offset; type 16 runs wake-and-shake.
// - Hall plus quadrature: commutate from Hall, resolution from counts.
// - Serial absolute data decoded as Gray or binary by configuration.
// - Serial word holds up to 16 position bits and 16 turn bits.
// - Gearing follows a secondary source; pulses per revolution programmable.
// - Step/direction input has adjustable steps per revolution.
// - Serial master uses emulation function 10, slave uses gearing source 25.
// - Supply fault raised when monitoring enabled and supply unused; bit 20 set enables monitoring.
module fgqe_top (
   input  wire logic                    sys_clk,
   input  wire logic                    sys_rst,
   input  wire logic [fgqe_pkg::POS_W-1:0] shaftPosition,
   input  wire logic                    resolverFeedback,
   input  wire logic                    safetyFitted,
   input  wire logic                    countReverse,
   input  wire logic [19:0]             emulationLineCount,
   input  wire logic [fgqe_pkg::POS_W-1:0] zeroPulseOffset,
   input  wire logic [4:0]              emulationFunctionSelect,
   input  wire logic [5:0]              feedbackTypeSelect,
   input  wire logic [4:0]              gearingSourceSelect,
   input  wire logic [15:0]             gearPulsesPerRev,
   input  wire logic [31:0]             driveConfigWord,
   input  wire logic                    encoderSupplyOn,
   input  wire logic                    auxPowerUp,
   input  wire logic [15:0]             storedPhaseOffset,
   input  wire logic                    shakeDone,
   input  wire logic [15:0]             shakePhaseOffset,
   input  wire logic                    fastIn1,
   input  wire logic                    fastIn2,
   input  wire logic [2:0]              hallState,
   input  wire logic                    serialValid,
   input  wire logic [fgqe_pkg::SER_W-1:0] serialWord,
   input  wire logic                    serialGray,
   output logic                         emuA,
   output logic                         emuB,
   output logic                         zeroPulse,
   output logic                         lineCountAccepted,
   output logic                         shakeStart,
   output logic                         positionControlReady,
   output logic [15:0]                  commutationPhaseOffset,
   output logic [2:0]                   commutationHall,
   output logic [31:0]                  gearSetpoint,
   output logic [15:0]                  serialPosition,
   output logic [15:0]                  serialTurns,
   output logic                         feedbackSupplyFault
);
   import fgqe_pkg::*;

   function automatic logic [15:0] gray2bin(input logic [15:0] g);
      logic [15:0] b;
      b = 16'h0000;
      b[15] = g[15];
      for (int i = 14; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   function automatic logic isPow2(input logic [19:0] v);
      return (v != 20'h00000) && ((v & (v - 20'h00001)) == 20'h00000);
   endfunction

   // Line count check
   wire lcRange = resolverFeedback
      ? (emulationLineCount >= LINES_RES_MIN && emulationLineCount <= LINES_RES_MAX)
      : (emulationLineCount >= LINES_ENC_MIN && emulationLineCount <= LINES_ENC_MAX);
   wire lcSafe  = !safetyFitted
      || (isPow2(emulationLineCount) && emulationLineCount <= LINES_SAFE_MAX);
   wire lcOk    = lcRange && lcSafe;

   logic [19:0]      lines_q;
   logic [POS_W-1:0] offset_q;
   logic [21:0]      emuCount_q;
   logic [1:0]       phase_q;
   logic             zero_q;
   logic             accepted_q;

   // Shaft position shifted by the zero offset, then scaled to quarter-lines
   wire [POS_W-1:0] relPos  = shaftPosition - offset_q;
   wire [POS_W-1:0] dirPos  = countReverse ? (POS_W'(0) - relPos) : relPos;
   wire [40:0]      scaled  = {22'h0, dirPos} * {19'h0, lines_q, 2'b00};
   wire [21:0]      quarter = scaled[40:19];
   wire [21:0]      perTurn = {lines_q, 2'b00};
   // Distance to target modulo one turn; the shorter way round wins, so a wrap steps one count across zero
   wire [21:0]      diffRaw = quarter - emuCount_q;
   wire [21:0]      diff    = (quarter >= emuCount_q) ? diffRaw : diffRaw + perTurn;
   wire             fwd     = (diff != 22'h0) && (diff < {1'b0, perTurn[21:1]});
   wire             bwd     = (diff != 22'h0) && !fwd;
   wire [1:0]       phaseUp = phase_q + 2'h1;
   wire [1:0]       phaseDn = phase_q - 2'h1;
   wire [21:0]      cntUp   = (emuCount_q[21:0] + 22'h1 >= perTurn) ? 22'h0
                                                                    : emuCount_q[21:0] + 22'h1;
   wire [21:0]      cntDn   = (emuCount_q[21:0] == 22'h0) ? perTurn - 22'h1
                                                          : emuCount_q[21:0] - 22'h1;
   wire [21:0]      cntNext = fwd ? cntUp : (bwd ? cntDn : emuCount_q[21:0]);
   // Quadrature state 2 is A=B=1; zero lands on the first line of the turn
   wire             zeroD   = (cntNext == 22'h2);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lines_q    <= LINES_RESET;
         offset_q   <= '0;
         accepted_q <= 1'b0;
      end else begin
         offset_q <= zeroPulseOffset;
         accepted_q <= lcOk;
         if (lcOk) begin
            lines_q <= emulationLineCount;
         end
      end
   end

   // One quadrature step per cycle at most, so no edge is skipped
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         emuCount_q <= '0;
         phase_q    <= 2'h0;
         zero_q     <= 1'b0;
      end else begin
         emuCount_q <= cntNext;
         if (fwd) begin
            phase_q <= phaseUp;
         end else if (bwd) begin
            phase_q <= phaseDn;
         end
         zero_q <= zeroD && (emulationFunctionSelect == EMU_FN_QUAD);
      end
   end

   // Phase 0:00 1:10 2:11 3:01 gives A leading B by 90 degrees
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         emuA <= 1'b0;
         emuB <= 1'b0;
      end else begin
         emuA <= (emulationFunctionSelect == EMU_FN_QUAD) && (phase_q[1] ^ phase_q[0]);
         emuB <= (emulationFunctionSelect == EMU_FN_QUAD) && phase_q[1];
      end
   end
   assign zeroPulse         = zero_q && emuA && emuB;
   assign lineCountAccepted = accepted_q;

   // Commutation start sequence
   fgqe_comm_t state_q;
   fgqe_comm_t state_d;
   logic [15:0] phaseOff_q;
   logic        ready_q;
   always_comb begin
      state_d = state_q;
      case (state_q)
         FGQE_ST_IDLE: begin
            if (feedbackTypeSelect == FBT_QUAD24_SHAKE) begin
               state_d = FGQE_ST_SHAKE;
            end else begin
               state_d = FGQE_ST_LOAD;
            end
         end
         FGQE_ST_LOAD:  state_d = FGQE_ST_RUN;
         FGQE_ST_SHAKE: begin
            if (shakeDone) begin
               state_d = FGQE_ST_RUN;
            end
         end
         FGQE_ST_RUN:   state_d = FGQE_ST_RUN;
         default:       state_d = FGQE_ST_IDLE;
      endcase
      if (auxPowerUp) begin
         state_d = FGQE_ST_IDLE;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q    <= FGQE_ST_IDLE;
         phaseOff_q <= 16'h0000;
         ready_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         ready_q <= (state_d == FGQE_ST_RUN);
         if (state_q == FGQE_ST_LOAD) begin
            phaseOff_q <= storedPhaseOffset;
         end else if (state_q == FGQE_ST_SHAKE && shakeDone) begin
            phaseOff_q <= shakePhaseOffset;
         end
      end
   end
   assign shakeStart             = (state_q == FGQE_ST_SHAKE);
   assign positionControlReady   = ready_q;
   assign commutationPhaseOffset = phaseOff_q;

   // Hall states pass three stages for commutation
   logic [2:0] hallS1_q;
   logic [2:0] hallS2_q;
   logic [2:0] hallS3_q;
   logic [2:0] hall_q;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         hallS1_q <= 3'h0;
         hallS2_q <= 3'h0;
         hallS3_q <= 3'h0;
         hall_q   <= 3'h0;
      end else begin
         hallS1_q <= hallState;
         hallS2_q <= hallS1_q;
         hallS3_q <= hallS2_q;
         if (hallS2_q == hallS3_q) begin
            hall_q <= hallS3_q;
         end
      end
   end
   assign commutationHall = hall_q;

   // Fast inputs: quadrature or step/direction, driven by the external source
   logic cntUp24;
   logic cntDn24;
   fgqe_quad_decoder uDecoder (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .stepMode  (gearingSourceSelect == GEAR_STEPDIR24),
      .pinA      (fastIn1),
      .pinB      (fastIn2),
      .countUp   (cntUp24),
      .countDown (cntDn24)
   );

   // Serial absolute word: turns in upper half, position in lower half
   logic [15:0] serPos_q;
   logic [15:0] serTurn_q;
   wire  [15:0] serPosD  = serialGray ? gray2bin(serialWord[15:0])  : serialWord[15:0];
   wire  [15:0] serTurnD = serialGray ? gray2bin(serialWord[31:16]) : serialWord[31:16];
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         serPos_q  <= 16'h0000;
         serTurn_q <= 16'h0000;
      end else if (serialValid) begin
         serPos_q  <= serPosD;
         serTurn_q <= serTurnD;
      end
   end
   assign serialPosition = serPos_q;
   assign serialTurns    = serTurn_q;

   // Gearing setpoint: counts scaled to pulses per revolution
   logic [31:0] gear_q;
   logic [15:0] pulse_q;
   wire  [15:0] ppr      = (gearPulsesPerRev == 16'h0) ? 16'h1 : gearPulsesPerRev;
   wire         gearCnt  = (gearingSourceSelect == GEAR_QUAD24)
                        || (gearingSourceSelect == GEAR_STEPDIR24);
   wire         pulseEnd = (pulse_q + 16'h1 == ppr);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         gear_q  <= 32'h0;
         pulse_q <= 16'h0;
      end else if (gearingSourceSelect == GEAR_SERIAL) begin
         gear_q <= {serTurn_q, serPos_q};
      end else if (gearCnt && cntUp24) begin
         pulse_q <= pulseEnd ? 16'h0 : pulse_q + 16'h1;
         gear_q  <= gear_q + {16'h0, pulseEnd, 15'h0};
      end else if (gearCnt && cntDn24) begin
         pulse_q <= (pulse_q == 16'h0) ? ppr - 16'h1 : pulse_q - 16'h1;
         gear_q  <= gear_q - {16'h0, (pulse_q == 16'h0), 15'h0};
      end
   end
   assign gearSetpoint = gear_q;

   // Supply monitoring
   logic fault_q;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= driveConfigWord[SUPPLY_MON_BIT] && !encoderSupplyOn;
      end
   end
   assign feedbackSupplyFault = fault_q;

   property p_zero_ab;
      @(posedge sys_clk) disable iff (sys_rst) zeroPulse |-> emuA && emuB;
   endproperty
   a_zero_ab: assert property (p_zero_ab) else $error("zero pulse outside A=B=1");

   property p_one_step;
      @(posedge sys_clk) disable iff (sys_rst)
         !(emuA != $past(emuA) && emuB != $past(emuB));
   endproperty
   a_one_step: assert property (p_one_step) else $error("A and B changed together");

   property p_fault;
      @(posedge sys_clk) disable iff (sys_rst)
         driveConfigWord[SUPPLY_MON_BIT] && !encoderSupplyOn |=> feedbackSupplyFault;
   endproperty
   a_fault: assert property (p_fault) else $error("supply fault missing");

   property p_nofault;
      @(posedge sys_clk) disable iff (sys_rst)
         !driveConfigWord[SUPPLY_MON_BIT] |=> !feedbackSupplyFault;
   endproperty
   a_nofault: assert property (p_nofault) else $error("fault while monitor off");

   sequence s_power;
      auxPowerUp ##1 !positionControlReady;
   endsequence
   property p_power;
      @(posedge sys_clk) disable iff (sys_rst) auxPowerUp |-> s_power;
   endproperty
   a_power: assert property (p_power) else $error("ready straight after power-up");

   property p_shake;
      @(posedge sys_clk) disable iff (sys_rst)
         $rose(shakeStart) |-> feedbackTypeSelect == FBT_QUAD24_SHAKE || $past(feedbackTypeSelect) == FBT_QUAD24_SHAKE;
   endproperty
   a_shake: assert property (p_shake) else $error("shake without type 16");

   property p_safe;
      @(posedge sys_clk) disable iff (sys_rst)
         safetyFitted && !isPow2(emulationLineCount) |=> !lineCountAccepted;
   endproperty
   a_safe: assert property (p_safe) else $error("non-binary count accepted");

   property p_range;
      @(posedge sys_clk) disable iff (sys_rst)
         resolverFeedback && emulationLineCount > LINES_RES_MAX |=> !lineCountAccepted;
   endproperty
   a_range: assert property (p_range) else $error("resolver count out of range");
endmodule
`default_nettype wire

// *** testbench/fgqe_pulse_source.sv ***
// Far-side pulse source: a 24 V quadrature encoder or a step/direction controller.
// Assumes the bench raises start for one cycle and waits for busy to fall.
`timescale 1ns/1ps
`default_nettype none
module fgqe_pulse_source #(
   parameter int EDGE_NS = 10000
) (
   input  wire logic       start,
   input  wire logic       stepMode,
   input  wire logic       dirUp,
   input  wire logic [7:0] edges,
   output logic            pinA,
   output logic            pinB,
   output logic            busy
);
   int phase;
   initial begin
      pinA = 1'b0;
      pinB = 1'b0;
      busy = 1'b0;
      phase = 0;
   end
   // Count spacing never under the 100 kHz count limit, sharp transitions
   always @(posedge start) begin
      busy = 1'b1;
      for (int i = 0; i < edges; i++) begin
         if (stepMode) begin
            // Direction level on the second input, one step pulse per count
            pinB = dirUp;
            #(EDGE_NS / 2) pinA = 1'b1;
            #(EDGE_NS / 2) pinA = 1'b0;
         end else begin
            phase = (phase + (dirUp ? 1 : 3)) % 4;
            #(EDGE_NS) {pinA, pinB} = (phase == 0) ? 2'b00 : (phase == 1) ? 2'b01 :
                                      (phase == 2) ? 2'b11 : 2'b10;
         end
      end
      #(EDGE_NS) busy = 1'b0;
   end
endmodule
`default_nettype wire

// *** testbench/tb_fgqe_top.sv ***
// Self-checking bench for the feedback, gearing and quadrature emulation block.
// Assumes the pulse source model on the fast inputs; all other inputs come from here.
`timescale 1ns/1ps
`default_nettype none
module tb_fgqe_top;
   import fgqe_pkg::*;
   logic sys_clk, sys_rst, resolverFeedback, safetyFitted, countReverse, encoderSupplyOn;
   logic auxPowerUp, shakeDone, serialValid, serialGray, fastIn1, fastIn2;
   logic [POS_W-1:0] shaftPosition, zeroPulseOffset;
   logic [19:0] emulationLineCount;
   logic [4:0] emulationFunctionSelect, gearingSourceSelect;
   logic [5:0] feedbackTypeSelect;
   logic [15:0] gearPulsesPerRev, storedPhaseOffset, shakePhaseOffset;
   logic [31:0] driveConfigWord, gearSetpoint, g0;
   logic [2:0] hallState, commutationHall;
   logic [SER_W-1:0] serialWord;
   logic emuA, emuB, zeroPulse, lineCountAccepted, shakeStart, positionControlReady;
   logic feedbackSupplyFault, prevA, prevB, prevZ, start, stepMode, dirUp, busy, watch;
   logic [15:0] commutationPhaseOffset, serialPosition, serialTurns;
   logic [7:0] edges;
   int fails, num_checks, trans, dirSum, zeroCnt, s0, k, d;
   int seed = 32'hc8a8;
   logic [POS_W-1:0] zeroPos, zp0;

   fgqe_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .shaftPosition(shaftPosition),
      .resolverFeedback(resolverFeedback), .safetyFitted(safetyFitted),
      .countReverse(countReverse), .emulationLineCount(emulationLineCount),
      .zeroPulseOffset(zeroPulseOffset), .emulationFunctionSelect(emulationFunctionSelect),
      .feedbackTypeSelect(feedbackTypeSelect), .gearingSourceSelect(gearingSourceSelect),
      .gearPulsesPerRev(gearPulsesPerRev), .driveConfigWord(driveConfigWord),
      .encoderSupplyOn(encoderSupplyOn), .auxPowerUp(auxPowerUp),
      .storedPhaseOffset(storedPhaseOffset), .shakeDone(shakeDone),
      .shakePhaseOffset(shakePhaseOffset), .fastIn1(fastIn1), .fastIn2(fastIn2),
      .hallState(hallState), .serialValid(serialValid), .serialWord(serialWord),
      .serialGray(serialGray), .emuA(emuA), .emuB(emuB), .zeroPulse(zeroPulse),
      .lineCountAccepted(lineCountAccepted), .shakeStart(shakeStart),
      .positionControlReady(positionControlReady),
      .commutationPhaseOffset(commutationPhaseOffset), .commutationHall(commutationHall),
      .gearSetpoint(gearSetpoint), .serialPosition(serialPosition),
      .serialTurns(serialTurns), .feedbackSupplyFault(feedbackSupplyFault));
   fgqe_pulse_source src (.start(start), .stepMode(stepMode), .dirUp(dirUp),
      .edges(edges), .pinA(fastIn1), .pinB(fastIn2), .busy(busy));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic note(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         fails++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task automatic tally_and_finish();
      if (fails == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   function automatic logic lineOk(input logic [19:0] n, input logic res, input logic saf);
      logic pow2 = (n & (n - 20'h1)) == 20'h0;
      if (saf && !(pow2 && n <= LINES_SAFE_MAX)) return 1'b0;
      return res ? (n >= LINES_RES_MIN && n <= LINES_RES_MAX)
                 : (n >= LINES_ENC_MIN && n <= LINES_ENC_MAX);
   endfunction

   function automatic logic [15:0] gray2bin(input logic [15:0] g);
      logic [15:0] b;
      b[15] = g[15];
      for (int i = 14; i >= 0; i--) b[i] = b[i + 1] ^ g[i];
      return b;
   endfunction

   function automatic int ph(input logic a, input logic b);
      return {a, b} == 2'b00 ? 0 : {a, b} == 2'b10 ? 1 : {a, b} == 2'b11 ? 2 : 3;
   endfunction

   // Watches every emulated edge; a double change would skip a count at the receiver
   always @(posedge sys_clk) begin
      if (!sys_rst && watch) begin
         note(!(emuA !== prevA && emuB !== prevB), "A and B moved together");
         note(!zeroPulse || (emuA && emuB), "zero pulse outside A=B=1");
         if ({emuA, emuB} !== {prevA, prevB}) begin
            trans++;
            dirSum += ((ph(emuA, emuB) - ph(prevA, prevB) + 4) % 4 == 1) ? 1 : -1;
         end
         if (zeroPulse && !prevZ) begin
            zeroCnt++;
            zeroPos = shaftPosition;
         end
      end
      prevA <= emuA;
      prevB <= emuB;
      prevZ <= zeroPulse;
   end

   task automatic sweep(input int n, input int stp);
      // Let the output catch up with a changed count, offset or direction first
      repeat (300) @(negedge sys_clk);
      trans = 0;
      dirSum = 0;
      zeroCnt = 0;
      repeat (n) @(negedge sys_clk) shaftPosition = shaftPosition + stp[POS_W-1:0];
      repeat (4) @(negedge sys_clk);
   endtask

   task automatic pulses(input logic sm, input logic up, input int n);
      stepMode = sm;
      dirUp = up;
      edges = n[7:0];
      @(negedge sys_clk) start = 1'b1;
      @(negedge sys_clk) start = 1'b0;
      for (k = 0; k < 30000 && busy; k++) @(negedge sys_clk);
      note(!busy, "pulse source hung");
      repeat (10) @(negedge sys_clk);
   endtask

   initial begin
      {resolverFeedback, safetyFitted, countReverse, auxPowerUp, shakeDone, serialValid} = '0;
      {serialGray, start, stepMode, dirUp, watch, prevA, prevB, prevZ} = '0;
      {shaftPosition, zeroPulseOffset, gearPulsesPerRev, driveConfigWord} = '0;
      {serialWord, hallState, edges, shakePhaseOffset} = '0;
      encoderSupplyOn = 1'b1;
      emulationLineCount = 20'h00020;
      emulationFunctionSelect = EMU_FN_QUAD;
      feedbackTypeSelect = FBT_QUAD24_STORE;
      gearingSourceSelect = GEAR_QUAD24;
      storedPhaseOffset = 16'h5a3c;
      sys_rst = 1'b1;
      repeat (12) @(negedge sys_clk);
      sys_rst = 1'b0;
      for (k = 0; k < 20 && positionControlReady !== 1'b1; k++) @(negedge sys_clk);
      note(positionControlReady === 1'b1, "not ready after stored load");
      note(commutationPhaseOffset === storedPhaseOffset, "stored offset");
      // Wake-and-shake restart: control must wait for the procedure
      feedbackTypeSelect = FBT_QUAD24_SHAKE;
      shakePhaseOffset = $random(seed);
      auxPowerUp = 1'b1;
      @(negedge sys_clk) auxPowerUp = 1'b0;
      for (k = 0; k < 10 && shakeStart !== 1'b1; k++) @(negedge sys_clk);
      note(shakeStart === 1'b1, "shake not started");
      repeat (20) @(negedge sys_clk);
      note(positionControlReady === 1'b0, "ready before shake done");
      shakeDone = 1'b1;
      @(negedge sys_clk) shakeDone = 1'b0;
      repeat (3) @(negedge sys_clk);
      note(positionControlReady === 1'b1, "not ready after shake");
      note(commutationPhaseOffset === shakePhaseOffset, "shake offset");
      // Line count table: corners and random values across both feedback kinds
      for (int i = 0; i < 24; i++) begin
         logic [19:0] n;
         n = (i < 12) ? (20'h1 << (i + 4)) + ((i % 3 == 0) ? 20'h1 : 20'h0)
                      : $random(seed) & 20'h01fff;
         resolverFeedback = i[0];
         safetyFitted = i[1];
         emulationLineCount = n;
         repeat (2) @(negedge sys_clk);
         note(lineCountAccepted === lineOk(n, i[0], i[1]), "line count verdict");
      end
      resolverFeedback = 1'b1;
      safetyFitted = 1'b0;
      emulationLineCount = 20'h00020;
      repeat (3) @(negedge sys_clk);
      watch = 1'b1;
      sweep(1024, 512);
      note(trans == 128, "edges per turn at 32 lines");
      note(zeroCnt == 1, "zero pulses per turn");
      zp0 = zeroPos;
      emulationLineCount = 20'h00010;
      sweep(1024, 512);
      note(trans == 128, "refused count changed output");
      emulationLineCount = 20'h00040;
      zeroPulseOffset = 19'h40000;
      sweep(1024, 512);
      note(trans == 256, "edges per turn at 64 lines");
      d = int'(zeroPos - zp0) - 32'h40000;
      note(zeroCnt == 1 && d > -12288 && d < 12288, "zero pulse offset");
      sweep(64, 512);
      s0 = dirSum;
      countReverse = 1'b1;
      sweep(64, 512);
      note(s0 >= 6 && dirSum == -s0, "count direction reversal");
      countReverse = 1'b0;
      emulationFunctionSelect = EMU_FN_SERIAL;
      sweep(64, 512);
      note({emuA, emuB, zeroPulse} === 3'b000 && trans == 0, "outputs off");
      emulationFunctionSelect = EMU_FN_QUAD;
      // Gearing from the 24 V quadrature input, then from step/direction
      gearPulsesPerRev = 16'h0008;
      g0 = gearSetpoint;
      pulses(1'b0, 1'b1, 8);
      d = int'(gearSetpoint - g0);
      note(d == 32768 || d == -32768, "quadrature gearing step");
      pulses(1'b0, 1'b0, 8);
      note(gearSetpoint === g0, "quadrature gearing return");
      gearingSourceSelect = GEAR_STEPDIR24;
      gearPulsesPerRev = 16'h0004;
      pulses(1'b1, 1'b1, 4);
      d = int'(gearSetpoint - g0);
      note(d == 32768 || d == -32768, "step gearing");
      gearingSourceSelect = GEAR_SERIAL;
      for (int i = 0; i < 8; i++) begin
         serialWord = $random(seed);
         serialGray = i[0];
         serialValid = 1'b1;
         @(negedge sys_clk) serialValid = 1'b0;
         repeat (2) @(negedge sys_clk);
         g0 = i[0] ? {gray2bin(serialWord[31:16]), gray2bin(serialWord[15:0])} : serialWord;
         note(serialPosition === g0[15:0], "serial position");
         note(serialTurns === g0[31:16], "serial turns");
         note(gearSetpoint === g0, "serial gearing");
      end
      for (int i = 0; i < 8; i++) begin
         hallState = $random(seed);
         driveConfigWord = $random(seed);
         encoderSupplyOn = i[1];
         repeat (8) @(negedge sys_clk);
         note(commutationHall === hallState, "hall state");
         note(feedbackSupplyFault === (driveConfigWord[SUPPLY_MON_BIT] && !i[1]),
              "supply fault");
      end
      tally_and_finish();
   end

   initial begin
      #800000;
      fails++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
